// ### src/fws_device.sv
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module fws_device
  import fws_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  fws_link_if.dev   link
);
  typedef enum logic [2:0] {
    ST_READ,
    ST_PROG,
    ST_WINDOW,
    ST_ERASE,
    ST_SUSP,
    ST_SUSP_PROG,
    ST_FAIL
  } fws_st_e;

  fws_st_e             st_r;
  logic [DATA_W-1:0]   mem_r [2**ADDR_W];
  logic [NUM_SECT-1:0] sel_r;
  logic [ADDR_W-1:0]   paddr_r;
  logic [DATA_W-1:0]   pdata_r;
  logic [15:0]         tmr_r;
  logic [6:0]          pulse_r;
  logic [3:0]          sub_r;
  logic                tog1_r;
  logic                tog2_r;
  logic                failed_r;
  logic                erase_fail_r;
  logic [DATA_W-1:0]   rdata_r;

  wire [SECT_BITS-1:0] rd_sect   = link.addr[ADDR_W-1 -: SECT_BITS];
  wire                 in_sel    = sel_r[rd_sect];
  wire                 prog_bad  = |(link.wdata & ~mem_r[link.addr]);
  wire                 pulse_end = sub_r == 4'(PULSE_CYC - 1);
  wire                 busy      = st_r == ST_PROG || st_r == ST_WINDOW || st_r == ST_ERASE ||
                                   st_r == ST_SUSP_PROG || st_r == ST_FAIL;
  wire                 is_erase  = st_r == ST_WINDOW || st_r == ST_ERASE;
  wire                 need      = st_r == ST_PROG || st_r == ST_SUSP_PROG;
  wire [6:0]           goal      = need ? 7'(PROG_PULSES) : 7'(ERASE_PULSES);
  wire                 hard_fail = need ? failed_r : erase_fail_r;

  // ==========================================================================
  // status byte assembly
  logic [DATA_W-1:0] status;
  always_comb begin
    status = '0;
    unique case (st_r)
      ST_PROG, ST_SUSP_PROG, ST_FAIL: begin
        if (st_r != ST_FAIL && is_erase == 1'b0 && 1'b1)
          status[POLL_BIT] = ~pdata_r[POLL_BIT];
        status[TOG1_BIT] = tog1_r;
        status[FAIL_BIT] = st_r == ST_FAIL;
      end
      ST_WINDOW, ST_ERASE: begin
        status[TOG1_BIT]   = tog1_r;
        status[WINDOW_BIT] = st_r == ST_ERASE;
        status[TOG2_BIT]   = in_sel ? tog2_r : 1'b0;
      end
      ST_SUSP: begin
        status[POLL_BIT] = 1'b1;
        status[TOG1_BIT] = tog1_r;
        status[TOG2_BIT] = tog2_r;
      end
      default: status = mem_r[link.addr];
    endcase
  end

  wire show_array = st_r == ST_READ || (st_r == ST_SUSP && !in_sel);
  // failure from erase shows program-style status: only toggle bit one keeps toggling, toggle bit two reads 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
      tog1_r  <= 1'b0;
      tog2_r  <= 1'b0;
    end else if (link.rd_stb) begin
      rdata_r <= show_array ? mem_r[link.addr] : status;
      if (busy)
        tog1_r <= ~tog1_r;
      if ((is_erase || st_r == ST_SUSP) && in_sel)
        tog2_r <= ~tog2_r;
    end
  end

  // ==========================================================================
  // embedded algorithm sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r         <= ST_READ;
      sel_r        <= '0;
      paddr_r      <= '0;
      pdata_r      <= '0;
      tmr_r        <= '0;
      pulse_r      <= '0;
      sub_r        <= '0;
      failed_r     <= 1'b0;
      erase_fail_r <= 1'b0;
    end else begin
      sub_r <= pulse_end ? 4'h0 : sub_r + 4'h1;
      unique case (st_r)
        ST_READ: if (link.wr_stb) begin
          pulse_r <= '0;
          unique case (link.op)
            OP_PROGRAM: begin
              st_r     <= ST_PROG;
              paddr_r  <= link.addr;
              pdata_r  <= link.wdata;
              failed_r <= prog_bad;
            end
            OP_SECT_ERASE: begin
              st_r  <= ST_WINDOW;
              sel_r <= NUM_SECT'(1) << rd_sect;
              tmr_r <= '0;
            end
            OP_CHIP_ERASE: begin
              st_r  <= ST_ERASE;
              sel_r <= '1;
            end
            default: ;
          endcase
        end
        ST_WINDOW: if (link.wr_stb && link.op == OP_SECT_ERASE) begin
          sel_r[rd_sect] <= 1'b1;
          tmr_r          <= '0;
        end else if (tmr_r == 16'(WINDOW_CYC - 1))
          st_r <= ST_ERASE;
        else
          tmr_r <= tmr_r + 16'h1;
        ST_PROG, ST_ERASE, ST_SUSP_PROG: begin
          if (st_r == ST_ERASE && link.wr_stb && link.op == OP_SUSPEND)
            st_r <= ST_SUSP;
          else if (pulse_end) begin
            pulse_r <= pulse_r + 7'h1;
            if (pulse_r == 7'(PULSE_LIMIT - 1))
              st_r <= ST_FAIL;
            else if (!hard_fail && pulse_r + 7'h1 == goal) begin
              if (need) mem_r[paddr_r] <= mem_r[paddr_r] & pdata_r;
              for (int i = 0; i < 2**ADDR_W; i++)
                if (!need && sel_r[i >> (ADDR_W - SECT_BITS)]) mem_r[i] <= '1;
              st_r  <= st_r == ST_SUSP_PROG ? ST_SUSP : ST_READ;
              if (!need) sel_r <= '0;
            end
          end
        end
        ST_SUSP: if (link.wr_stb) begin
          if (link.op == OP_RESUME) st_r <= ST_ERASE;
          else if (link.op == OP_PROGRAM && !sel_r[rd_sect]) begin
            st_r     <= ST_SUSP_PROG;
            paddr_r  <= link.addr;
            pdata_r  <= link.wdata;
            failed_r <= prog_bad;
          end
        end
        ST_FAIL: if (link.wr_stb && link.op == OP_RESET) begin
          st_r     <= ST_READ;
          failed_r <= 1'b0;
          sel_r    <= '0;
        end
        default: st_r <= ST_READ;
      endcase
    end
  end

  assign link.rdata             = rdata_r;
  assign link.ready_busy_output = ~busy;
endmodule : fws_device

// ### src/fws_pkg.sv
package fws_pkg;
  // ==========================================================================
  // link widths and command codes
  localparam int        ADDR_W          = 8;
  localparam int        DATA_W          = 8;
  localparam int        SECT_BITS       = 2;
  localparam int        NUM_SECT        = 4;
  localparam logic [1:0] CMD_NONE       = 2'h0;
  localparam logic [2:0] OP_PROGRAM     = 3'h0;
  localparam logic [2:0] OP_SECT_ERASE  = 3'h1;
  localparam logic [2:0] OP_CHIP_ERASE  = 3'h2;
  localparam logic [2:0] OP_SUSPEND     = 3'h3;
  localparam logic [2:0] OP_RESUME      = 3'h4;
  localparam logic [2:0] OP_RESET       = 3'h5;

  // ==========================================================================
  // status bit positions in the low status byte
  localparam int POLL_BIT   = 7;
  localparam int TOG1_BIT   = 6;
  localparam int FAIL_BIT   = 5;
  localparam int WINDOW_BIT = 3;
  localparam int TOG2_BIT   = 2;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ          = 40;
  localparam int WINDOW_US        = 50;
  localparam int WINDOW_CYC       = WINDOW_US * CLK_MHZ;
  localparam int PULSE_LIMIT      = 64;
  localparam int PROG_PULSES      = 4;
  localparam int ERASE_PULSES     = 16;
  localparam int PULSE_CYC        = 8;

  // ==========================================================================
  // host side registers (wishbone byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_IRQ_ST = 4'hC;
  localparam logic [3:0] REG_IRQ_MK = 4'h0;
  localparam int         IRQ_DONE   = 0;
  localparam int         IRQ_FAIL   = 1;
  localparam int         IRQ_REJ    = 2;
  localparam logic [2:0] IRQ_RESET  = 3'h0;

  typedef enum logic [1:0] {
    RES_BUSY,
    RES_OK,
    RES_FAIL,
    RES_IDLE
  } fws_res_e;
endpackage : fws_pkg

// ### src/fws_link_if.sv
`timescale 1ns/1ps
interface fws_link_if;
  import fws_pkg::*;
  logic              rd_stb;
  logic              wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [2:0]        op;
  logic [DATA_W-1:0] rdata;
  logic              ready_busy_output;

  modport dev  (input rd_stb, wr_stb, addr, wdata, op, output rdata, ready_busy_output);
  modport host (output rd_stb, wr_stb, addr, wdata, op, input rdata, ready_busy_output);
endinterface : fws_link_if

// ### src/fws_host.sv
`timescale 1ns/1ps
module fws_host
  import fws_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  fws_link_if.host         link
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_CMD,
    H_RD1,
    H_RD2,
    H_CMP,
    H_RESET
  } fws_hst_e;

  fws_hst_e          st_r;
  logic [2:0]        op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] first_r;
  logic              recheck_r;
  fws_res_e          res_r;
  logic [2:0]        irq_st_r;
  logic [2:0]        irq_mk_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  logic [2:0]        ev;

  // ==========================================================================
  // wishbone slave: one wait state, ack one cycle
  wire req      = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr       = req && wb_we_i && wb_sel_i[0];
  // one command per procedure: no extra sector erase is ever queued behind it
  wire wr_ctrl  = wr && wb_adr_i == REG_CTRL && st_r == H_IDLE;
  wire wr_addr  = wr && wb_adr_i == REG_ADDR;
  wire wr_clr   = wr && wb_adr_i == REG_IRQ_ST;
  wire [31:0] rd_mux = wb_adr_i == REG_RESULT ? {22'h0, res_r, first_r} :
                       wb_adr_i == REG_IRQ_ST ? {21'h0, irq_mk_r, 5'h0, irq_st_r} :
                       wb_adr_i == REG_ADDR   ? {16'h0, wdata_r, addr_r} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      dat_r    <= '0;
      irq_st_r <= IRQ_RESET;
      irq_mk_r <= IRQ_RESET;
      addr_r   <= '0;
      wdata_r  <= '0;
    end else begin
      ack_r <= req;
      if (req) dat_r <= rd_mux;
      if (wr_addr) begin
        addr_r  <= wb_dat_i[ADDR_W-1:0];
        wdata_r <= wb_dat_i[ADDR_W+DATA_W-1:ADDR_W];
      end
      if (wr_clr) irq_mk_r <= wb_dat_i[10:8];
      // set wins over write-one-to-clear
      irq_st_r <= (irq_st_r & ~(wr_clr ? wb_dat_i[2:0] : 3'h0)) | ev;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o    = |(irq_st_r & irq_mk_r);

  // ==========================================================================
  // toggle-bit polling procedure
  wire togg = first_r[TOG1_BIT] != link.rdata[TOG1_BIT];
  wire fail = link.rdata[FAIL_BIT];
  always_comb begin
    ev = 3'h0;
    if (st_r == H_CMP && !togg) ev[IRQ_DONE] = 1'b1;
    if (st_r == H_CMP && togg && fail && recheck_r) ev[IRQ_FAIL] = 1'b1;
    if (st_r == H_CMP && !togg && op_r == OP_SECT_ERASE && link.rdata[WINDOW_BIT] && 1'b0)
      ev[IRQ_REJ] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= H_IDLE;
      op_r      <= OP_PROGRAM;
      first_r   <= '0;
      recheck_r <= 1'b0;
      res_r     <= RES_IDLE;
    end else begin
      unique case (st_r)
        H_IDLE: if (wr_ctrl) begin
          op_r  <= wb_dat_i[2:0];
          st_r  <= H_CMD;
          res_r <= RES_BUSY;
        end
        H_CMD: begin
          recheck_r <= 1'b0;
          st_r <= (op_r == OP_RESET || op_r == OP_SUSPEND) ? H_IDLE : H_RD1;
          if (op_r == OP_RESET || op_r == OP_SUSPEND) res_r <= RES_OK;
        end
        H_RD1: st_r <= H_RD2;
        H_RD2: begin
          first_r <= link.rdata;
          st_r    <= H_CMP;
        end
        H_CMP: begin
          first_r <= link.rdata;
          if (!togg) begin
            st_r  <= H_IDLE;
            res_r <= RES_OK;
          end else if (fail && !recheck_r) begin
            recheck_r <= 1'b1;
            st_r      <= H_RD2;
          end else if (fail) begin
            st_r  <= H_RESET;
            res_r <= RES_FAIL;
          end else
            st_r <= H_RD2;
        end
        H_RESET: st_r <= H_IDLE;
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.rd_stb = st_r == H_RD1 || st_r == H_RD2 || st_r == H_CMP;
  assign link.wr_stb = st_r == H_CMD || st_r == H_RESET;
  assign link.op     = st_r == H_RESET ? OP_RESET : op_r;
  assign link.addr   = addr_r;
  assign link.wdata  = wdata_r;
endmodule : fws_host

// ### verification/fws_link_chk.sv
`timescale 1ns/1ps
module fws_link_chk
  import fws_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              rd_stb,
  input wire logic              wr_stb,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [2:0]        op,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              ready_busy_output
);
  // ==========================================================================
  // helper state
  localparam int FAIL_MIN = PULSE_LIMIT * PULSE_CYC - 16;
  localparam int WIN_LO   = 1990;
  localparam int WIN_HI   = 2010;
  logic        win_open_r;
  logic [11:0] win_cnt_r;
  logic [9:0]  busy_cnt_r;
  wire         sect_cmd = wr_stb && (op == OP_SECT_ERASE);
  wire         busy     = !ready_busy_output;
  wire         win_late = win_open_r && win_cnt_r > WIN_HI && win_cnt_r < 12'hFFF;

  // any other command ends our view of the window: the window checks switch off and a_reset_ready switches on
  always_ff @(posedge clk_i) begin
    win_open_r <= !rst_i && (sect_cmd || (win_open_r && !wr_stb));
    win_cnt_r  <= (rst_i || sect_cmd) ? 12'h000 : win_cnt_r + {11'h0, win_cnt_r != 12'hFFF};
    busy_cnt_r <= (rst_i || !busy) ? 10'h000 : busy_cnt_r + {9'h0, busy_cnt_r != 10'h3FF};
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_busy_rd; rd_stb && busy; endsequence
  sequence s_idle_rd; rd_stb && !busy; endsequence

  a_toggle_flips: assert property (
    s_busy_rd ##1 s_busy_rd |=> rdata[TOG1_BIT] != $past(rdata[TOG1_BIT]))
    else $error("toggle bit one held between busy reads");
  a_toggle_stops: assert property (
    s_idle_rd ##1 (s_idle_rd and $stable(addr)) |=> $stable(rdata[TOG1_BIT]))
    else $error("toggle bit one moved while ready");
  a_prog_busy: assert property (
    wr_stb && op == OP_PROGRAM && !busy |-> ##[1:4] busy)
    else $error("program did not go busy");
  a_prog_ends: assert property (
    wr_stb && op == OP_PROGRAM && !busy |-> ##[1:1000] !busy)
    else $error("program never finished");
  a_fail_late: assert property (
    rd_stb && busy && busy_cnt_r < FAIL_MIN |=> !rdata[FAIL_BIT])
    else $error("failure flag before pulse limit");
  a_window_low: assert property (
    rd_stb && busy && win_open_r && win_cnt_r < WIN_LO |=> !rdata[WINDOW_BIT])
    else $error("window flag high inside window");
  a_window_high: assert property (
    rd_stb && busy && win_late |=> rdata[WINDOW_BIT] && !rdata[POLL_BIT])
    else $error("erase status wrong after window");
  a_erase_ignores: assert property (
    wr_stb && op != OP_SUSPEND && busy && win_late |=> busy)
    else $error("command taken during erase");
  a_reset_ready: assert property (
    wr_stb && op == OP_RESET && !win_open_r |-> ##[1:64] !busy)
    else $error("reset did not return ready");
endmodule : fws_link_chk

// ### verification/flash_write_status_reporting_tb.sv
`timescale 1ns/1ps
module flash_write_status_reporting_tb;
  import fws_pkg::*;
  typedef struct packed {logic [31:0] exp; logic [31:0] msk;} fws_note_s;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_we_i  = 1'b0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic [31:0] rd_val;
  logic [7:0]  ra;
  logic [7:0]  rdat;
  fws_note_s   cur;
  fws_note_s   notes[$];
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cyc_n     = 0;

  fws_link_if link ();
  fws_device i_fws_device (.clk_i(clk_i), .rst_i(rst_i), .link(link));
  fws_host i_fws_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .link(link));
  fws_link_chk i_fws_link_chk (.clk_i(clk_i), .rst_i(rst_i), .rd_stb(link.rd_stb),
    .wr_stb(link.wr_stb), .addr(link.addr), .wdata(link.wdata), .op(link.op),
    .rdata(link.rdata), .ready_busy_output(link.ready_busy_output));

  always #12.5 clk_i = ~clk_i;

  // ==========================================================================
  // checking
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // polls carry a zero mask and are not compared
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.msk != 32'h0) check(wb_dat_o & cur.msk, cur.exp & cur.msk);
    end
  end

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // bus tasks
  task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic we);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    wb(a, 32'h0, 1'b0);
  endtask : rd

  function automatic logic [31:0] res_w(input fws_res_e r, input logic [7:0] b);
    return {22'h0, r, b};
  endfunction : res_w

  task automatic run(input logic [2:0] o, input logic [7:0] a, input logic [7:0] d,
                     input logic [31:0] e, input logic [31:0] m, input int lim);
    int n;
    n = 0;
    wb(REG_IRQ_ST, 32'h7, 1'b1);
    wb(REG_ADDR, {16'h0, d, a}, 1'b1);
    wb(REG_CTRL, {29'h0, o}, 1'b1);
    rd_val = 32'h0;
    while (rd_val[1:0] === 2'b00 && n < lim) begin
      rd(REG_IRQ_ST, 32'h0, 32'h0);
      n++;
    end
    rd(REG_RESULT, e, m);
  endtask : run

  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(32'hf37c));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    run(OP_CHIP_ERASE, 8'h00, 8'h00, res_w(RES_OK, 8'hFF), 32'h3FF, 4000);
    run(OP_PROGRAM, 8'h10, 8'h3C, res_w(RES_OK, 8'h3C), 32'h3FF, 4000);
    // one bit from zero back to one must fail
    run(OP_PROGRAM, 8'h10, 8'h7C, res_w(RES_FAIL, 8'h00), 32'h300, 4000);
    rd(REG_IRQ_ST, 32'h2, 32'h3);
    run(OP_PROGRAM, 8'h10, 8'h0C, res_w(RES_OK, 8'h0C), 32'h3FF, 4000);
    run(OP_SECT_ERASE, 8'h10, 8'h00, res_w(RES_OK, 8'hFF), 32'h3FF, 4000);
    ra = 8'($urandom);
    rdat = 8'($urandom);
    run(OP_PROGRAM, {2'b00, ra[5:0]}, rdat, res_w(RES_OK, rdat), 32'h3FF, 4000);
    // done is pending but masked, so the line stays low until the mask opens
    check({31'h0, irq_o}, 32'h0);
    wb(REG_IRQ_ST, 32'h700, 1'b1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    rd(REG_IRQ_ST, 32'h701, 32'h707);
    wb(REG_IRQ_ST, 32'h7, 1'b1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    rd(REG_IRQ_ST, 32'h0, 32'h7);
    rd(4'h6, 32'h0, 32'hFFFFFFFF);
    run(OP_SUSPEND, 8'h10, 8'h00, res_w(RES_OK, 8'h00), 32'h300, 50);
    // sector one was never touched after the chip erase
    run(OP_RESUME, 8'h50, 8'h00, res_w(RES_OK, 8'hFF), 32'h3FF, 50);
    run(OP_RESET, 8'h10, 8'h00, res_w(RES_OK, 8'h00), 32'h300, 50);
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule : flash_write_status_reporting_tb
